/* inc/ieg_pkg.sv */
// Constants, types and decode helpers for the interrupt enable gating block
// What this block does
// - Global gate bit 7 of first enable register clear blocks every source.
// - With gate set, a request passes only when its own enable bit is set.
// - First enable register: audio, decoder, serial, timer one, ext one, timer zero, ext zero.
// - Second enable register: USB bit 6, keypad, converter, SPI, two-wire, card bit 0.
// - Second register bits 7 and 5 read zero; software never writes ones there.
// - Bit 1 of first register passes or suppresses the timer zero overflow request.
// - Each source carries a two-bit level from upper and lower bits, 11 highest.
// - Equal-level requests resolve by fixed polling order, external zero first, USB last.
// - Edge-mode external flags are cleared by hardware on vectoring; level flags are not.
package ieg_pkg;
	localparam int SRC_COUNT = 14;
	typedef logic [SRC_COUNT-1:0] ieg_src_t;

	// Register byte addresses on the core port
	localparam logic [7:0] ADDR_ENABLE_FIRST = 8'hA8;
	localparam logic [7:0] ADDR_ENABLE_SECOND = 8'hB1;
	localparam logic [7:0] ADDR_UPPER_FIRST = 8'hB7;
	localparam logic [7:0] ADDR_UPPER_SECOND = 8'hB3;
	localparam logic [7:0] ADDR_LOWER_FIRST = 8'hB8;
	localparam logic [7:0] ADDR_LOWER_SECOND = 8'hB2;
	localparam logic [7:0] ADDR_STATUS_FIRST = 8'hC0;
	localparam logic [7:0] ADDR_STATUS_SECOND = 8'hC1;
	localparam logic [7:0] ADDR_MASK_FIRST = 8'hC2;
	localparam logic [7:0] ADDR_MASK_SECOND = 8'hC3;

	// Storage indices; odd indices use the second-register layout
	localparam logic [2:0] IDX_ENABLE_FIRST = 3'h0;
	localparam logic [2:0] IDX_ENABLE_SECOND = 3'h1;
	localparam logic [2:0] IDX_UPPER_FIRST = 3'h2;
	localparam logic [2:0] IDX_UPPER_SECOND = 3'h3;
	localparam logic [2:0] IDX_LOWER_FIRST = 3'h4;
	localparam logic [2:0] IDX_LOWER_SECOND = 3'h5;
	localparam logic [2:0] IDX_MASK_FIRST = 3'h6;
	localparam logic [2:0] IDX_MASK_SECOND = 3'h7;
	localparam int REG_COUNT = 8;

	// Field positions and implemented-bit masks
	localparam int GATE_BIT = 7;
	localparam int TIMER_ZERO_BIT = 1;
	localparam logic [7:0] FIRST_IMPL_MASK = 8'h7F;
	localparam logic [7:0] SECOND_IMPL_MASK = 8'h5F;
	localparam logic [7:0] GATE_IMPL_MASK = 8'hFF;
	localparam logic [7:0] REG_RESET = 8'h00;

	// Polling slots of the sources that need special handling
	localparam logic [3:0] POLL_EXT_ZERO = 4'h0;
	localparam logic [3:0] POLL_EXT_ONE = 4'h2;

	// Address decode: {hit, index}
	function automatic logic [3:0] ieg_decode(input logic [7:0] addr);
		case (addr)
			ADDR_ENABLE_FIRST: ieg_decode = {1'b1, IDX_ENABLE_FIRST};
			ADDR_ENABLE_SECOND: ieg_decode = {1'b1, IDX_ENABLE_SECOND};
			ADDR_UPPER_FIRST: ieg_decode = {1'b1, IDX_UPPER_FIRST};
			ADDR_UPPER_SECOND: ieg_decode = {1'b1, IDX_UPPER_SECOND};
			ADDR_LOWER_FIRST: ieg_decode = {1'b1, IDX_LOWER_FIRST};
			ADDR_LOWER_SECOND: ieg_decode = {1'b1, IDX_LOWER_SECOND};
			ADDR_MASK_FIRST: ieg_decode = {1'b1, IDX_MASK_FIRST};
			ADDR_MASK_SECOND: ieg_decode = {1'b1, IDX_MASK_SECOND};
			default: ieg_decode = 4'h0;
		endcase
	endfunction

	// Bits that software may set in a stored register
	function automatic logic [7:0] ieg_write_mask(input logic [2:0] idx);
		if (idx == IDX_ENABLE_FIRST)
			ieg_write_mask = GATE_IMPL_MASK;
		else if (idx[0])
			ieg_write_mask = SECOND_IMPL_MASK;
		else
			ieg_write_mask = FIRST_IMPL_MASK;
	endfunction

	// Two register bytes to one vector in polling order; slot 12 stays empty
	function automatic ieg_src_t ieg_src_vec(input logic [7:0] first, input logic [7:0] second);
		ieg_src_vec = {second[6:0] & SECOND_IMPL_MASK[6:0], first[6:0]};
	endfunction

	// Priority level of one slot
	function automatic logic [1:0] ieg_level(input ieg_src_t up, input ieg_src_t lo, input int idx);
		ieg_level = {up[idx], lo[idx]};
	endfunction
endpackage

/* inc/ieg_reg_if.sv */
// Carrier between the gating core and its register file
`timescale 1ns/1ps
interface ieg_reg_if;
	logic wrStb;
	logic rdStb;
	logic [7:0] addr;
	logic [7:0] wrData;
	logic [7:0] rdData;
	logic globalGate;
	ieg_pkg::ieg_src_t srcEnable;
	ieg_pkg::ieg_src_t prioUpper;
	ieg_pkg::ieg_src_t prioLower;
	ieg_pkg::ieg_src_t events;
	logic irq;
	modport regs
	(
		input wrStb, rdStb, addr, wrData, events,
		output rdData, globalGate, srcEnable, prioUpper, prioLower, irq
	);
	modport core
	(
		output wrStb, rdStb, addr, wrData, events,
		input rdData, globalGate, srcEnable, prioUpper, prioLower, irq
	);
endinterface

/* hw/ieg_regs.sv */
// Register file: enables, priority bits, sticky event status and mask
`timescale 1ns/1ps
module ieg_regs
(
	input wire logic clk,
	input wire logic rstSyncN,
	ieg_reg_if.regs bus
);
	logic [7:0] regFile [ieg_pkg::REG_COUNT];
	logic [7:0] next_regFile [ieg_pkg::REG_COUNT];
	ieg_pkg::ieg_src_t status;
	ieg_pkg::ieg_src_t next_status;
	logic [7:0] next_rdData;
	logic [3:0] dec;
	ieg_pkg::ieg_src_t clearVec;

	assign dec = ieg_pkg::ieg_decode(bus.addr);

	// Writes store only implemented bits, so reserved bits always read zero
	always_comb
	begin
		next_regFile = regFile;
		clearVec = '0;
		if (bus.wrStb && dec[3])
			next_regFile[dec[2:0]] = bus.wrData & ieg_pkg::ieg_write_mask(dec[2:0]);
		if (bus.wrStb && bus.addr == ieg_pkg::ADDR_STATUS_FIRST)
			clearVec = ieg_pkg::ieg_src_vec(bus.wrData, 8'h00);
		if (bus.wrStb && bus.addr == ieg_pkg::ADDR_STATUS_SECOND)
			clearVec = ieg_pkg::ieg_src_vec(8'h00, bus.wrData);
		// A new event wins over a clear in the same cycle
		next_status = (status & ~clearVec) | bus.events;
	end

	// Read mux; data stand only in the cycle after the strobe
	always_comb
	begin
		next_rdData = 8'h00;
		if (bus.rdStb)
		begin
			if (dec[3])
				next_rdData = regFile[dec[2:0]];
			else if (bus.addr == ieg_pkg::ADDR_STATUS_FIRST)
				next_rdData = {1'b0, status[6:0]};
			else if (bus.addr == ieg_pkg::ADDR_STATUS_SECOND)
				next_rdData = {1'b0, status[13:7]};
		end
	end

	// Register stage
	always_ff @(posedge clk or negedge rstSyncN)
	begin
		if (!rstSyncN)
		begin
			for (int i = 0; i < ieg_pkg::REG_COUNT; i++)
				regFile[i] <= ieg_pkg::REG_RESET;
			status <= '0;
			bus.rdData <= 8'h00;
		end
		else
		begin
			regFile <= next_regFile;
			status <= next_status;
			bus.rdData <= next_rdData;
		end
	end

	// Decoded views used by the gating core
	assign bus.globalGate = regFile[ieg_pkg::IDX_ENABLE_FIRST][ieg_pkg::GATE_BIT];
	assign bus.srcEnable = ieg_pkg::ieg_src_vec(regFile[ieg_pkg::IDX_ENABLE_FIRST],
		regFile[ieg_pkg::IDX_ENABLE_SECOND]);
	assign bus.prioUpper = ieg_pkg::ieg_src_vec(regFile[ieg_pkg::IDX_UPPER_FIRST],
		regFile[ieg_pkg::IDX_UPPER_SECOND]);
	assign bus.prioLower = ieg_pkg::ieg_src_vec(regFile[ieg_pkg::IDX_LOWER_FIRST],
		regFile[ieg_pkg::IDX_LOWER_SECOND]);
	assign bus.irq = |(status & ieg_pkg::ieg_src_vec(regFile[ieg_pkg::IDX_MASK_FIRST],
		regFile[ieg_pkg::IDX_MASK_SECOND]));
endmodule

/* hw/ieg_top.sv */
// Interrupt enable gating with level and polling arbitration
`timescale 1ns/1ps
module ieg_top
(
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic [7:0] regAddr,
	input wire logic [7:0] regWrData,
	input wire logic regWrStb,
	input wire logic regRdStb,
	output logic [7:0] regRdData,
	input wire ieg_pkg::ieg_src_t srcRequest,
	input wire logic [1:0] extEdgeMode,
	input wire logic vectorTaken,
	output ieg_pkg::ieg_src_t gatedRequest,
	output logic winnerValid,
	output logic [3:0] winnerIndex,
	output logic [1:0] winnerLevel,
	output logic [1:0] extFlagClear,
	output logic irqOut
);
	logic [1:0] rstPipe;
	logic [1:0] next_rstPipe;
	logic rstSyncN;
	ieg_pkg::ieg_src_t next_gatedRequest;
	ieg_pkg::ieg_src_t gatedPrev;
	ieg_pkg::ieg_src_t next_gatedPrev;
	logic next_winnerValid;
	logic [3:0] next_winnerIndex;
	logic [1:0] next_winnerLevel;
	logic [1:0] next_extFlagClear;

	ieg_reg_if regBus();

	// Reset release through two stages; assertion side is asynchronous
	always_comb
	begin
		next_rstPipe = {rstPipe[0], 1'b1};
	end

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			rstPipe <= 2'h0;
		else
			rstPipe <= next_rstPipe;
	end

	assign rstSyncN = rstPipe[1];

	// Core port into the register file; the core never waits
	assign regBus.wrStb = regWrStb;
	assign regBus.rdStb = regRdStb;
	assign regBus.addr = regAddr;
	assign regBus.wrData = regWrData;
	assign regRdData = regBus.rdData;
	assign irqOut = regBus.irq;

	ieg_regs regFileInst
	(
		.clk(sys_clk),
		.rstSyncN(rstSyncN),
		.bus(regBus.regs)
	);

	// Gate: global bit first, then the per-source enable
	always_comb
	begin
		next_gatedRequest = srcRequest & regBus.srcEnable
			& {ieg_pkg::SRC_COUNT{regBus.globalGate}};
		next_gatedPrev = gatedRequest;
	end

	always_ff @(posedge sys_clk or negedge rstSyncN)
	begin
		if (!rstSyncN)
		begin
			gatedRequest <= '0;
			gatedPrev <= '0;
		end
		else
		begin
			gatedRequest <= next_gatedRequest;
			gatedPrev <= next_gatedPrev;
		end
	end

	// A newly passed request is the event that sets a sticky status bit
	assign regBus.events = gatedRequest & ~gatedPrev;

	// Arbitration: highest level wins; walking downward with >= lets the
	// lowest polling slot win a tie at the same level
	always_comb
	begin
		next_winnerValid = 1'b0;
		next_winnerIndex = 4'h0;
		next_winnerLevel = 2'h0;
		for (int i = ieg_pkg::SRC_COUNT - 1; i >= 0; i--)
		begin
			if (gatedRequest[i] && (!next_winnerValid
				|| ieg_pkg::ieg_level(regBus.prioUpper, regBus.prioLower, i)
				>= next_winnerLevel))
			begin
				next_winnerValid = 1'b1;
				next_winnerIndex = 4'(i);
				next_winnerLevel = ieg_pkg::ieg_level(regBus.prioUpper, regBus.prioLower, i);
			end
		end
	end

	always_ff @(posedge sys_clk or negedge rstSyncN)
	begin
		if (!rstSyncN)
		begin
			winnerValid <= 1'b0;
			winnerIndex <= 4'h0;
			winnerLevel <= 2'h0;
		end
		else
		begin
			winnerValid <= next_winnerValid;
			winnerIndex <= next_winnerIndex;
			winnerLevel <= next_winnerLevel;
		end
	end

	// Flag clear on vectoring, only for edge-mode external inputs;
	// level-mode flags stay set so the service routine must clear them
	always_comb
	begin
		next_extFlagClear = 2'h0;
		if (vectorTaken && winnerValid)
		begin
			if (winnerIndex == ieg_pkg::POLL_EXT_ZERO && extEdgeMode[0])
				next_extFlagClear[0] = 1'b1;
			if (winnerIndex == ieg_pkg::POLL_EXT_ONE && extEdgeMode[1])
				next_extFlagClear[1] = 1'b1;
		end
	end

	always_ff @(posedge sys_clk or negedge rstSyncN)
	begin
		if (!rstSyncN)
			extFlagClear <= 2'h0;
		else
			extFlagClear <= next_extFlagClear;
	end

	// Reference arbitration for the checks below, computed a different way:
	// first find the top level, then the first slot that holds it
	logic [1:0] refLevel;
	logic [3:0] refIndex;
	logic refFound;

	always_comb
	begin
		refLevel = 2'h0;
		refIndex = 4'h0;
		refFound = 1'b0;
		for (int i = 0; i < ieg_pkg::SRC_COUNT; i++)
		begin
			if (gatedRequest[i]
				&& ieg_pkg::ieg_level(regBus.prioUpper, regBus.prioLower, i) > refLevel)
				refLevel = ieg_pkg::ieg_level(regBus.prioUpper, regBus.prioLower, i);
		end
		for (int i = 0; i < ieg_pkg::SRC_COUNT; i++)
		begin
			if (!refFound && gatedRequest[i]
				&& ieg_pkg::ieg_level(regBus.prioUpper, regBus.prioLower, i) == refLevel)
			begin
				refFound = 1'b1;
				refIndex = 4'(i);
			end
		end
	end

	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rstSyncN);

	// A write that closes the gate clears every gated request two cycles on
	gate_closed_a: assert property (
		regWrStb && regAddr == ieg_pkg::ADDR_ENABLE_FIRST && !regWrData[ieg_pkg::GATE_BIT]
		|-> ##2 gatedRequest == '0)
		else $error("request passed with global gate closed");

	// With the gate open, exactly the enabled requests pass one cycle later
	source_pass_a: assert property (
		regBus.globalGate
		|=> gatedRequest == $past(srcRequest & regBus.srcEnable))
		else $error("gated request does not follow enables");

	// Layout of the first enable register
	first_layout_a: assert property (
		regWrStb && regAddr == ieg_pkg::ADDR_ENABLE_FIRST
		|=> regBus.srcEnable[6:0] == $past(regWrData[6:0])
			&& regBus.globalGate == $past(regWrData[ieg_pkg::GATE_BIT]))
		else $error("first enable register layout wrong");

	// Layout of the second enable register
	second_layout_a: assert property (
		regWrStb && regAddr == ieg_pkg::ADDR_ENABLE_SECOND
		|=> regBus.srcEnable[13:7] == ($past(regWrData[6:0]) & 7'h5F))
		else $error("second enable register layout wrong");

	// Reserved bits of the second enable register read zero
	reserved_zero_a: assert property (
		regRdStb && regAddr == ieg_pkg::ADDR_ENABLE_SECOND
		|=> regRdData[7] == 1'b0 && regRdData[5] == 1'b0)
		else $error("reserved enable bit read as one");

	// Timer zero overflow follows bit 1 of the first register
	timer_zero_a: assert property (
		##1 gatedRequest[1] == $past(regBus.globalGate
			&& regBus.srcEnable[ieg_pkg::TIMER_ZERO_BIT] && srcRequest[1]))
		else $error("timer zero gate wrong");

	// Winner carries the highest pending level
	level_order_a: assert property (
		|gatedRequest |=> winnerValid && winnerLevel == $past(refLevel))
		else $error("winner level is not the highest pending");

	// Ties resolve to the lowest polling slot
	poll_order_a: assert property (
		|gatedRequest |=> winnerIndex == $past(refIndex))
		else $error("polling order tie broken wrongly");

	// Edge-mode external zero flag is cleared on vectoring, level mode is not
	edge_clear_a: assert property (
		vectorTaken && winnerValid && winnerIndex == ieg_pkg::POLL_EXT_ZERO
		|=> extFlagClear[0] == $past(extEdgeMode[0]))
		else $error("external zero flag clear wrong");

	// No hardware clear without a vectoring request
	no_stray_clear_a: assert property (
		!vectorTaken |=> extFlagClear == 2'h0)
		else $error("flag clear without vectoring");

	// Enable register reads back what was written
	readback_a: assert property (
		regWrStb && regAddr == ieg_pkg::ADDR_ENABLE_FIRST
		##1 regRdStb && regAddr == ieg_pkg::ADDR_ENABLE_FIRST && !regWrStb
		|=> regRdData == $past(regWrData, 2))
		else $error("enable register read back differs");

	// Read data appear only in the cycle after a read strobe
	read_idle_a: assert property (
		!regRdStb |=> regRdData == 8'h00)
		else $error("read data without strobe");

	timer_pass_c: cover property (
		regBus.globalGate && regBus.srcEnable[1] && srcRequest[1] ##1 gatedRequest[1]);

	tie_top_c: cover property (
		gatedRequest[0] && gatedRequest[13] && refLevel == 2'h3 ##1 winnerIndex == 4'h0);

	edge_clear_c: cover property (
		extFlagClear[0] || extFlagClear[1]);

	irq_raise_c: cover property (
		!irqOut ##1 irqOut);
endmodule

/* tb/ieg_flag_model.sv */
// Peripheral request flag model that faces the gating block
`timescale 1ns/1ps
module ieg_flag_model
(
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire ieg_pkg::ieg_src_t setReq,
	input wire ieg_pkg::ieg_src_t clrReq,
	input wire logic [1:0] extFlagClear,
	output ieg_pkg::ieg_src_t srcRequest
);
	ieg_pkg::ieg_src_t flags;
	ieg_pkg::ieg_src_t hwClear;
	logic spare;
	// Hardware clear reaches only the two external slots
	assign hwClear = {11'h000, extFlagClear[1], 1'b0, extFlagClear[0]};
	// Flags stay pending until software or hardware clears them
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			flags <= '0;
			spare <= 1'b0;
		end
		else
		begin
			flags <= (flags & ~clrReq & ~hwClear) | setReq;
			spare <= ~spare;
		end
	end
	// Unused slot toggles every cycle, so no one can lean on its level
	assign srcRequest = {flags[13], spare, flags[11:0]};
endmodule

/* tb/interrupt_enable_gating_test.sv */
// Self-checking bench for the interrupt enable gating block
`timescale 1ns/1ps
module interrupt_enable_gating_test;
	logic sys_clk, rst_n, regWrStb, regRdStb, vectorTaken, winnerValid, irqOut;
	logic [7:0] regAddr, regWrData, regRdData, e1, e2, u1, u2, l1, l2;
	logic [1:0] extEdgeMode, extFlagClear, winnerLevel;
	logic [3:0] winnerIndex;
	ieg_pkg::ieg_src_t srcRequest, gatedRequest, setReq, clrReq, r;
	int errors, testsRun, i, slot;
	logic edgeOn;

	ieg_top uut (.sys_clk(sys_clk), .rst_n(rst_n), .regAddr(regAddr), .regWrData(regWrData),
		.regWrStb(regWrStb), .regRdStb(regRdStb), .regRdData(regRdData),
		.srcRequest(srcRequest), .extEdgeMode(extEdgeMode), .vectorTaken(vectorTaken),
		.gatedRequest(gatedRequest), .winnerValid(winnerValid), .winnerIndex(winnerIndex),
		.winnerLevel(winnerLevel), .extFlagClear(extFlagClear), .irqOut(irqOut));
	ieg_flag_model flagModel (.sys_clk(sys_clk), .rst_n(rst_n), .setReq(setReq),
		.clrReq(clrReq), .extFlagClear(extFlagClear), .srcRequest(srcRequest));

	// Free-running core clock
	initial
	begin
		sys_clk = 1'b0;
		forever #2.5 sys_clk = ~sys_clk;
	end

	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		testsRun++;
		if (got !== exp)
		begin
			errors++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Single bus cycles; each leaves one idle cycle after its strobe
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		regAddr <= a;
		regWrData <= d;
		regWrStb <= 1'b1;
		@(posedge sys_clk);
		regWrStb <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge sys_clk);
		regAddr <= a;
		regRdStb <= 1'b1;
		@(posedge sys_clk);
		regRdStb <= 1'b0;
		#1;
		check(regRdData, exp);
	endtask

	// Write then read the same register with no idle cycle between the strobes
	task automatic wr_rd(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		regAddr <= a;
		regWrData <= d;
		regWrStb <= 1'b1;
		@(posedge sys_clk);
		regWrStb <= 1'b0;
		regRdStb <= 1'b1;
		@(posedge sys_clk);
		regRdStb <= 1'b0;
		#1;
		check(regRdData, d);
	endtask

	task automatic flag(input ieg_pkg::ieg_src_t s, input ieg_pkg::ieg_src_t c);
		@(posedge sys_clk);
		setReq <= s;
		clrReq <= c;
		@(posedge sys_clk);
		setReq <= '0;
		clrReq <= '0;
	endtask

	// Enough cycles for gating, arbitration and status to settle
	task automatic settle();
		repeat (4) @(posedge sys_clk);
		#1;
	endtask

	task automatic pulse();
		@(posedge sys_clk);
		vectorTaken <= 1'b1;
		@(posedge sys_clk);
		vectorTaken <= 1'b0;
		#1;
	endtask

	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", testsRun, errors);
		if (errors == 0 && testsRun > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// Two register bytes laid out in polling order; slot 12 never enabled
	function automatic ieg_pkg::ieg_src_t vec(input logic [7:0] a, input logic [7:0] b);
		vec = {b[6], 1'b0, b[4:0], a[6:0]};
	endfunction

	// Highest level wins, lowest slot breaks a tie: {valid, level, index}
	function automatic logic [6:0] win(input ieg_pkg::ieg_src_t g, input ieg_pkg::ieg_src_t up,
		input ieg_pkg::ieg_src_t lo);
		logic [6:0] w;
		w = '0;
		for (int s = 0; s < 14; s++)
			if (g[s] && (!w[6] || {up[s], lo[s]} > w[5:4]))
				w = {1'b1, up[s], lo[s], 4'(s)};
		win = w;
	endfunction

	// Watchdog sized well above the whole sequence
	initial
	begin
		#100000;
		errors++;
		stop_test();
	end

	initial
	begin
		rst_n = 1'b0;
		regAddr = 8'h00;
		regWrData = 8'h00;
		regWrStb = 1'b0;
		regRdStb = 1'b0;
		vectorTaken = 1'b0;
		extEdgeMode = 2'h0;
		setReq = '0;
		clrReq = '0;
		errors = 0;
		testsRun = 0;
		void'($urandom(14806));
		repeat (8) @(posedge sys_clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge sys_clk);
		rd(ieg_pkg::ADDR_ENABLE_FIRST, 8'h00);
		rd(ieg_pkg::ADDR_ENABLE_SECOND, 8'h00);
		rd(8'h55, 8'h00);
		// Every implemented bit set; software keeps reserved bits clear, and they read zero
		wr(ieg_pkg::ADDR_ENABLE_SECOND, 8'h5F);
		rd(ieg_pkg::ADDR_ENABLE_SECOND, 8'h5F);
		$display("test registers done");
		// Random enables, levels and requests; first rows are hand-picked corners
		for (i = 0; i < 40; i++)
		begin
			e1 = 8'($urandom);
			e2 = 8'($urandom) & 8'h5F;
			u1 = 8'($urandom) & 8'h7F;
			u2 = 8'($urandom) & 8'h5F;
			l1 = 8'($urandom) & 8'h7F;
			l2 = 8'($urandom) & 8'h5F;
			r = 14'($urandom);
			if (i == 0)
				{e1, e2, r} = {8'h7F, 8'h5F, 14'h3FFF};
			if (i == 1)
				{e1, r} = {8'h82, 14'h0002};
			if (i == 2)
				{e1, r} = {8'h80, 14'h0002};
			wr_rd(ieg_pkg::ADDR_ENABLE_FIRST, e1);
			wr(ieg_pkg::ADDR_ENABLE_SECOND, e2);
			wr(ieg_pkg::ADDR_UPPER_FIRST, u1);
			wr(ieg_pkg::ADDR_UPPER_SECOND, u2);
			wr(ieg_pkg::ADDR_LOWER_FIRST, l1);
			wr(ieg_pkg::ADDR_LOWER_SECOND, l2);
			flag(r, '1);
			settle();
			check(gatedRequest, e1[7] ? r & vec(e1, e2) : '0);
			check({winnerValid, winnerLevel & {2{winnerValid}}, winnerIndex & {4{winnerValid}}},
				win(e1[7] ? r & vec(e1, e2) : '0, vec(u1, u2), vec(l1, l2)));
			rd(ieg_pkg::ADDR_ENABLE_FIRST, e1);
			rd(ieg_pkg::ADDR_ENABLE_SECOND, e2);
		end
		$display("test gating done");
		// Sticky status, mask and level interrupt
		flag('0, '1);
		wr(ieg_pkg::ADDR_MASK_FIRST, 8'h02);
		wr(ieg_pkg::ADDR_MASK_SECOND, 8'h00);
		wr(ieg_pkg::ADDR_ENABLE_FIRST, 8'h83);
		wr(ieg_pkg::ADDR_STATUS_FIRST, 8'hFF);
		wr(ieg_pkg::ADDR_STATUS_SECOND, 8'hFF);
		settle();
		check(irqOut, 1'b0);
		flag(14'h0001, '0);
		settle();
		check(irqOut, 1'b0);
		flag(14'h0002, '0);
		settle();
		check(irqOut, 1'b1);
		rd(ieg_pkg::ADDR_STATUS_FIRST, 8'h03);
		wr(ieg_pkg::ADDR_STATUS_FIRST, 8'h02);
		settle();
		check(irqOut, 1'b0);
		rd(ieg_pkg::ADDR_STATUS_FIRST, 8'h01);
		$display("test interrupt done");
		// Vectoring to each external input in edge and in level mode
		for (i = 0; i < 4; i++)
		begin
			slot = 2 * (i % 2);
			edgeOn = (i < 2);
			flag('0, '1);
			wr(ieg_pkg::ADDR_ENABLE_FIRST, 8'h80 | 8'(1 << slot));
			extEdgeMode <= {2{edgeOn}};
			flag(14'(1 << slot), '0);
			settle();
			check(winnerIndex, 4'(slot));
			pulse();
			check(extFlagClear, edgeOn ? 2'(1 << (slot / 2)) : 2'h0);
			settle();
			check(srcRequest[slot], !edgeOn);
		end
		$display("test vectoring done");
		stop_test();
	end
endmodule
